// file: hw/tdcr_defines.svh
`ifndef TDCR_DEFINES_SVH
`define TDCR_DEFINES_SVH
`define TDCR_FIFO_DEPTH  15
`define TDCR_FIFO_LAST   4'hE
`define TDCR_FIFO_FULL   4'hF
`define TDCR_PIPE_BITS   6'd5
`define TDCR_TAIL_BITS   6'd2
`define TDCR_TAG_VAL     1'b1
`define TDCR_ADDR_CTRL   8'h00
`define TDCR_ADDR_CMD    8'h04
`define TDCR_ADDR_STAT   8'h08
`define TDCR_ADDR_COUNT  8'h0C
`define TDCR_LAST_PAGE   4'h1
`define TDCR_CAL_PAGE    2'h1
`define TDCR_CTRL_RESET  32'h0000_1304
`define TDCR_CTRL_MASK   32'h001F_1377
`define TDCR_CMD_OT_CLR  0
`define TDCR_MASK_18     34'h0_0003_FFFF
`define TDCR_MASK_27     34'h0_07FF_FFFF
`define TDCR_MASK_34     34'h3_FFFF_FFFF
`define TDCR_HALF_75     4'h4
`define TDCR_HALF_150    4'h2
`define TDCR_HALF_300    4'h1
`endif

// file: hw/tdcr_pkg.sv
package tdcr_pkg;
   typedef struct packed {
      logic [10:0] rsv_hi;
      logic        sync_pol;
      logic [3:0]  event_pol;
      logic [2:0]  rsv_b;
      logic        mon_en;
      logic [1:0]  rsv_a;
      logic [1:0]  range;
      logic        rsv_c;
      logic        ddr;
      logic [1:0]  clk_sel;
      logic        rsv_d;
      logic [2:0]  length;
   } tdcr_ctrl_t;
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
   } tdcr_ahb_req_t;
endpackage

// file: hw/tdcr_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "tdcr_defines.svh"
module tdcr_fifo
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Fill side
   input  wire logic        push,
   input  wire logic [39:0] push_data,
   // Drain side
   input  wire logic        pop,
   output wire logic [39:0] head,
   output wire logic        full,
   output wire logic        empty
);
   logic [39:0] mem [`TDCR_FIFO_DEPTH];
   logic [3:0]  wr_ptr;
   logic [3:0]  rd_ptr;
   logic [3:0]  count;

   // A full FIFO drops the new stamp even when a pop lands in the same cycle
   wire do_push = push && !full;
   wire do_pop  = pop && !empty;

   assign full  = (count == `TDCR_FIFO_FULL);
   assign empty = (count == 4'h0);
   assign head  = mem[rd_ptr];

   function automatic logic [3:0] ptr_inc(input logic [3:0] p);
      ptr_inc = (p == `TDCR_FIFO_LAST) ? 4'h0 : p + 4'h1;
   endfunction

   always_ff @(posedge clk)
   begin
      if (do_push)
         mem[wr_ptr] <= push_data;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         count  <= 4'h0;
      end
      else
      begin
         if (do_push)
            wr_ptr <= ptr_inc(wr_ptr);
         if (do_pop)
            rd_ptr <= ptr_inc(rd_ptr);
         if (do_push && !do_pop)
            count <= count + 4'h1;
         else if (do_pop && !do_push)
            count <= count - 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   depth_limit_a: assert property (push && !pop && count == `TDCR_FIFO_LAST |=> full)
      else $error("fifteenth entry did not fill fifo");
   empty_flag_a: assert property (pop && !push && count == 4'h1 |=> empty)
      else $error("last pop did not empty fifo");
   full_drop_a: assert property (push && full && !pop |=> full && $stable(wr_ptr))
      else $error("push into full fifo was taken");
endmodule // tdcr_fifo
`default_nettype wire

// file: hw/tdcr_shifter.sv
`timescale 1ns/100ps
`default_nettype none
module tdcr_shifter
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Timing
   input  wire logic        bit_en,
   input  wire logic        load,
   // Word to send
   input  wire logic        valid,
   input  wire logic        tag,
   input  wire logic [39:0] word,
   input  wire logic [5:0]  len,
   // Serial pins
   output var  logic        data,
   output var  logic        strobe
);
   logic [39:0] sreg;
   logic [5:0]  left;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sreg   <= 40'h00_0000_0000;
         left   <= 6'h00;
         data   <= 1'b0;
         strobe <= 1'b1;
      end
      else if (bit_en)
      begin
         if (load && valid)
         begin
            data   <= tag;
            sreg   <= word;
            left   <= len;
            strobe <= 1'b0;
         end
         else if (left != 6'h00)
         begin
            data   <= sreg[0];
            sreg   <= {1'b0, sreg[39:1]};
            left   <= left - 6'h01;
            strobe <= 1'b0;
         end
         else
         begin
            // Idle and tail bit times carry no data
            data   <= 1'b0;
            strobe <= 1'b1;
         end
      end
   end
endmodule // tdcr_shifter
`default_nettype wire

// file: hw/tdcr_result_path.sv
// Added by the designer: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "tdcr_defines.svh"
module tdcr_result_path
   import tdcr_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic        hreadyout,
   output var  logic        hresp,
   output var  logic [31:0] hrdata,
   // Measurement pins
   input  wire logic [3:0]  event_in,
   input  wire logic        sync_in,
   input  wire logic        overtemp_sense,
   // Result link
   output var  logic        result_clk,
   output wire logic [3:0]  result_data,
   output wire logic [3:0]  result_strobe,
   // Overtemperature
   output var  logic        overtemp_alarm_pin_o,
   output var  logic        overtemp_alarm_pin_oe,
   output var  logic        power_down
);
   tdcr_ctrl_t    ctrl;
   tdcr_ahb_req_t req_q;
   logic [31:0]   cal_mem [16];
   logic [5:0]    pin_meta;
   logic [5:0]    pin_sync;
   logic [5:0]    pin_prev;
   logic [33:0]   coarse;
   logic [33:0]   sync_stamp;
   logic          overtemp_flag;
   logic [3:0]    half_cnt;
   logic          phase;
   logic [5:0]    frame_pos;
   logic [5:0]    len_q;
   logic [39:0]   alu_q [4];
   logic [3:0]    alu_vld;
   logic [3:0]    fifo_full;
   logic [3:0]    fifo_empty;
   logic [39:0]   fifo_head [4];
   logic [31:0]   rd_mux;
   logic          sign_hold;
   logic          sent_vld;

   function automatic logic edge_hit(input logic pol, input logic now, input logic was);
      edge_hit = pol ? (was && !now) : (!was && now);
   endfunction

   function automatic logic [5:0] len_of(input logic [2:0] sel);
      case (sel)
         3'h0:    len_of = 6'd8;
         3'h1:    len_of = 6'd16;
         3'h2:    len_of = 6'd24;
         3'h3:    len_of = 6'd32;
         default: len_of = 6'd40;
      endcase
   endfunction

   // Low n-1 bits of the result, the result's sign in bit n-1
   function automatic logic [39:0] place_sign(input logic [39:0] v, input logic [5:0] n);
      logic [39:0] top;
      top = 40'h00_0000_0001 << (n - 6'h01);
      place_sign = (v & (top - 40'h00_0000_0001)) | (v[39] ? top : 40'h00_0000_0000);
   endfunction

   // Pin decode
   wire capt_en = !power_down;
   wire ot_lvl  = pin_sync[5];
   wire sync_hit = capt_en && edge_hit(ctrl.sync_pol, pin_sync[4], pin_prev[4]);

   // Counter range; the reserved code keeps the widest counter
   wire [33:0] range_mask = (ctrl.range == 2'b01) ? `TDCR_MASK_18 :
                            (ctrl.range == 2'b10) ? `TDCR_MASK_27 :
                            `TDCR_MASK_34;

   // Bit-rate divider; the reserved select runs at the slowest rate
   wire [3:0] half_div = (ctrl.clk_sel == 2'b01) ? `TDCR_HALF_150 :
                         (ctrl.clk_sel == 2'b10) ? `TDCR_HALF_300 :
                         `TDCR_HALF_75;
   wire half_en = (half_cnt >= half_div - 4'h1);
   wire mid_en  = half_en && !phase;
   wire bit_en  = half_en && phase;

   // Frame timing
   wire [5:0] len_sel     = len_of(ctrl.length);
   wire       frame_start = bit_en && (frame_pos == len_q + `TDCR_TAIL_BITS);
   wire       load_pulse  = bit_en && (frame_pos + `TDCR_PIPE_BITS == len_q + `TDCR_TAIL_BITS);

   // Bus decode
   wire addr_ok = hsel && htrans[1] && hready && (hsize == 3'b010) && (haddr[31:8] == 24'h00_0000);
   wire wr_now  = req_q.valid && req_q.write;
   wire wr_ctrl = wr_now && (req_q.addr == `TDCR_ADDR_CTRL);
   wire wr_cmd  = wr_now && (req_q.addr == `TDCR_ADDR_CMD);
   wire wr_cal  = wr_now && (req_q.addr[7:6] == `TDCR_CAL_PAGE);
   wire ot_clear = wr_cmd && hwdata[`TDCR_CMD_OT_CLR];
   wire [7:0] rd_addr = haddr[7:0];

   always_comb
   begin
      if (rd_addr == `TDCR_ADDR_CTRL)
         rd_mux = ctrl;
      else if (rd_addr == `TDCR_ADDR_STAT)
         rd_mux = {22'h00_0000, power_down, overtemp_flag, fifo_empty, fifo_full};
      else if (rd_addr == `TDCR_ADDR_COUNT)
         rd_mux = coarse[31:0];
      else if (rd_addr[7:4] == `TDCR_LAST_PAGE)
         rd_mux = alu_q[rd_addr[3:2]][31:0];
      else if (rd_addr[7:6] == `TDCR_CAL_PAGE)
         rd_mux = cal_mem[rd_addr[5:2]];
      else
         rd_mux = 32'h0000_0000;
   end

   // Pins cross into core_clk through two flops before use
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pin_meta <= 6'h00;
         pin_sync <= 6'h00;
         pin_prev <= 6'h00;
      end
      else
      begin
         pin_meta <= {overtemp_sense, sync_in, event_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   // Zero-wait slave: read data is latched in the address phase
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         req_q     <= '0;
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         req_q.valid <= addr_ok;
         req_q.write <= hwrite;
         req_q.addr  <= rd_addr;
         if (addr_ok && !hwrite)
            hrdata <= rd_mux;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         ctrl <= `TDCR_CTRL_RESET;
      else if (wr_ctrl)
         ctrl <= hwdata & `TDCR_CTRL_MASK;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 16; i++)
            cal_mem[i] <= 32'h0000_0000;
      end
      else if (wr_cal)
         cal_mem[req_q.addr[5:2]] <= hwdata;
   end

   // One stamp counter serves the sync and every event channel
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         coarse     <= 34'h0_0000_0000;
         sync_stamp <= 34'h0_0000_0000;
      end
      else
      begin
         coarse <= (coarse + 34'h0_0000_0001) & range_mask;
         if (sync_hit)
            sync_stamp <= coarse;
      end
   end

   // A new event wins over a clear in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         overtemp_flag         <= 1'b0;
         power_down            <= 1'b0;
         overtemp_alarm_pin_o  <= 1'b0;
         overtemp_alarm_pin_oe <= 1'b0;
      end
      else
      begin
         overtemp_flag         <= (overtemp_flag && !ot_clear) || (ctrl.mon_en && ot_lvl);
         power_down            <= overtemp_flag;
         overtemp_alarm_pin_oe <= overtemp_flag;
      end
   end

   // Shared result clock: rising edge sits mid-bit so the receiver samples a settled bit
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         half_cnt   <= 4'h0;
         phase      <= 1'b0;
         result_clk <= 1'b0;
      end
      else
      begin
         half_cnt <= half_en ? 4'h0 : half_cnt + 4'h1;
         if (half_en)
            phase <= !phase;
         if (mid_en)
            result_clk <= ctrl.ddr ? !result_clk : 1'b1;
         else if (bit_en && !ctrl.ddr)
            result_clk <= 1'b0;
      end
   end

   // Free-running frame counter, blind to capture timing
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         frame_pos <= 6'h00;
         len_q     <= 6'd40;
         sign_hold <= 1'b0;
         sent_vld  <= 1'b0;
      end
      else if (frame_start)
      begin
         frame_pos <= 6'h00;
         len_q     <= len_sel;
         sign_hold <= alu_q[0][39];
         sent_vld  <= alu_vld[0];
      end
      else if (bit_en)
         frame_pos <= frame_pos + 6'h01;
   end

   for (genvar ch = 0; ch < 4; ch++)
   begin : g_ch
      logic [39:0] alu;
      logic        vld;
      wire         hit = capt_en && edge_hit(ctrl.event_pol[ch], pin_sync[ch], pin_prev[ch]);
      wire [3:0]   cal_idx = {2'(ch), ctrl.sync_pol, ctrl.event_pol[ch]};
      wire [39:0]  cal_ext = {{8{cal_mem[cal_idx][31]}}, cal_mem[cal_idx]};
      wire [39:0]  diff = fifo_head[ch] - {6'h00, sync_stamp} + cal_ext;

      assign alu_q[ch]   = alu;
      assign alu_vld[ch] = vld;

      tdcr_fifo u_fifo
      (
         .clk       (core_clk),
         .rst       (rst),
         .push      (hit),
         .push_data ({6'h00, coarse}),
         .pop       (load_pulse),
         .head      (fifo_head[ch]),
         .full      (fifo_full[ch]),
         .empty     (fifo_empty[ch])
      );

      always_ff @(posedge core_clk)
      begin
         if (rst)
         begin
            alu <= 40'h00_0000_0000;
            vld <= 1'b0;
         end
         else if (load_pulse)
         begin
            // An empty pop keeps the last result readable and stale slots out of it
            if (!fifo_empty[ch])
               alu <= diff;
            vld <= !fifo_empty[ch];
         end
      end

      tdcr_shifter u_shift
      (
         .clk    (core_clk),
         .rst    (rst),
         .bit_en (bit_en),
         .load   (frame_start),
         .valid  (vld),
         .tag    (`TDCR_TAG_VAL),
         .word   (place_sign(alu, len_sel)),
         .len    (len_sel),
         .data   (result_data[ch]),
         .strobe (result_strobe[ch])
      );
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   tail_high_a: assert property (bit_en && frame_pos == len_q |=> result_strobe == 4'hF)
      else $error("strobe not high in frame tail");
   tag_first_a: assert property (frame_start && alu_vld[0] |=> !result_strobe[0] && result_data[0])
      else $error("frame did not open with tag");
   sign_last_a: assert property (sent_vld && bit_en && frame_pos + 6'h01 == len_q |=>
                                 result_data[0] == sign_hold && !result_strobe[0])
      else $error("last data bit is not the sign");
   load_lead_a: assert property (load_pulse |-> ##[1:200] frame_start)
      else $error("load pulse not followed by frame start");
   ot_set_a: assert property (ctrl.mon_en && ot_lvl |=> overtemp_flag ##1 power_down)
      else $error("alarm did not set flag and power down");
   ot_gate_a: assert property (!ctrl.mon_en && !overtemp_flag |=> !overtemp_flag)
      else $error("flag set with monitor disabled");
endmodule // tdcr_result_path
`default_nettype wire

// file: sim/tdcr_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module tdcr_rx_model
(
   // Link
   input  wire logic        result_clk,
   input  wire logic        rst,
   input  wire logic        data,
   input  wire logic        strobe,
   // Received frame
   output var  logic        got,
   output var  logic        tag,
   output var  logic [45:0] frame
);
   logic [5:0]  cnt;
   logic [39:0] word;
   initial
   begin
      cnt = 6'h0;
      got = 1'b0;
   end
   // Rising edges only, so DDR frames are not decoded here
   always @(posedge result_clk or posedge rst)
      if (rst)
      begin
         cnt <= 6'h0;
         got <= 1'b0;
      end
      else
      begin
         got <= 1'b0;
         if (!strobe)
         begin
            cnt <= cnt + 6'h1;
            if (cnt == 6'h0)
            begin
               tag  <= data;
               word <= 40'h0;
            end
            else
               word[cnt - 6'h1] <= data;
         end
         else if (cnt != 6'h0)
         begin
            got   <= 1'b1;
            frame <= {cnt, word};
            cnt   <= 6'h0;
         end
      end
endmodule // tdcr_rx_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tdcr_defines.svh"
`define CHK(g, e) \
   begin \
      check_count++; \
      if ((g) !== (e)) \
      begin \
         n_fail++; \
         $display("wrong value at %0t: got %h expected %h", $time, g, e); \
      end \
   end
module tb;
   logic        core_clk, rst, hsel, hwrite, hreadyout, hresp, sync_in, overtemp_sense;
   logic        result_clk, ot_o, ot_oe, power_down, rd_vld;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [3:0]  event_in, result_data, result_strobe;
   logic [31:0] haddr, hwdata, hrdata, rd_data, rd_e, rd_m, rnd;
   logic [45:0] fe;
   logic        rx_got [4];
   logic        rx_tag [4];
   logic [45:0] rx_frame [4];
   logic [45:0] exp_q [4][$];
   logic [31:0] re_q [$];
   logic [31:0] rm_q [$];
   int          n_fail, check_count, cycles, seed, d;
   int          cal_a [4];
   time         t0;

   tdcr_result_path tdcr_result_path_i
   (
      .core_clk              (core_clk),
      .rst                   (rst),
      .hsel                  (hsel),
      .haddr                 (haddr),
      .htrans                (htrans),
      .hwrite                (hwrite),
      .hsize                 (hsize),
      .hwdata                (hwdata),
      .hready                (hreadyout),
      .hreadyout             (hreadyout),
      .hresp                 (hresp),
      .hrdata                (hrdata),
      .event_in              (event_in),
      .sync_in               (sync_in),
      .overtemp_sense        (overtemp_sense),
      .result_clk            (result_clk),
      .result_data           (result_data),
      .result_strobe         (result_strobe),
      .overtemp_alarm_pin_o  (ot_o),
      .overtemp_alarm_pin_oe (ot_oe),
      .power_down            (power_down)
   );

   for (genvar c = 0; c < 4; c++)
   begin : g_rx
      tdcr_rx_model tdcr_rx_model_i
      (
         .result_clk (result_clk),
         .rst        (rst),
         .data       (result_data[c]),
         .strobe     (result_strobe[c]),
         .got        (rx_got[c]),
         .tag        (rx_tag[c]),
         .frame      (rx_frame[c])
      );
   end

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard: the full sequence needs roughly 15000 cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize  <= 3'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd_data = hrdata;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      bus(1'b0, a, 32'h0);
      re_q.push_back(e);
      rm_q.push_back(m);
      rd_vld <= 1'b1;
      @(posedge core_clk);
      rd_vld <= 1'b0;
   endtask

   // Channel 4 stands for the sync input
   task automatic pulse(input int ch);
      if (ch == 4)
         sync_in <= 1'b1;
      else
         event_in[ch] <= 1'b1;
      repeat (2) @(posedge core_clk);
      if (ch == 4)
         sync_in <= 1'b0;
      else
         event_in[ch] <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic expect_res(input int ch, input int dv, input int len);
      logic [39:0] r;
      r = 40'(dv + cal_a[ch]);
      exp_q[ch].push_back({6'(len + 1), (r & ((40'h1 << (len - 1)) - 40'h1)) | (40'(r[39]) << (len - 1))});
   endtask

   task automatic drain;
      int n;
      n = 0;
      while (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() != 0 && n < 8000)
      begin
         @(posedge core_clk);
         n++;
      end
      `CHK(n < 8000, 1'b1)
   endtask

   always @(posedge core_clk)
      if (rd_vld === 1'b1)
      begin
         rd_m = rm_q.pop_front();
         rd_e = re_q.pop_front();
         `CHK(rd_data & rd_m, rd_e)
      end

   always @(posedge result_clk)
      for (int c = 0; c < 4; c++)
         if (rx_got[c] === 1'b1)
         begin
            `CHK(rx_tag[c], `TDCR_TAG_VAL)
            `CHK(exp_q[c].size() > 0, 1'b1)
            fe = (exp_q[c].size() > 0) ? exp_q[c].pop_front() : 46'h0;
            `CHK(rx_frame[c], fe)
         end

   initial
   begin
      seed = 32'h23fa;
      {rst, hsel, hwrite, htrans, hsize, haddr, hwdata} = {1'b1, 71'h0};
      {event_in, sync_in, overtemp_sense, rd_vld} = 7'h0;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(`TDCR_ADDR_CTRL, `TDCR_CTRL_RESET, 32'hFFFF_FFFF);
      rd(`TDCR_ADDR_STAT, 32'h0000_00F0, 32'h0000_03FF);
      rnd = $random(seed);
      bus(1'b1, `TDCR_ADDR_CTRL, rnd);
      rd(`TDCR_ADDR_CTRL, rnd & `TDCR_CTRL_MASK, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0, 32'hFFFF_FFFF);
      rd(`TDCR_ADDR_CMD, 32'h0, 32'hFFFF_FFFF);
      `CHK({hresp, ot_o}, 2'b00)
      // Length codes 0 to 4, channels in turn, each with its own correction
      for (int i = 0; i < 5; i++)
      begin
         cal_a[i % 4] = $random(seed) % 64;
         bus(1'b1, 8'h40 + 8'(16 * (i % 4)), 32'(cal_a[i % 4]));
         bus(1'b1, `TDCR_ADDR_CTRL, 32'h0000_1300 | 32'(i));
         repeat (700) @(posedge core_clk);
         d = $random(seed) & 15;
         pulse(4);
         repeat (d) @(posedge core_clk);
         pulse(i % 4);
         expect_res(i % 4, 4 + d, 8 * (i + 1));
         drain();
         rd(8'h10 + 8'(4 * (i % 4)), 32'(4 + d + cal_a[i % 4]), 32'hFFFF_FFFF);
      end
      // Event waiting in the queue when a newer sync arrives
      pulse(4);
      pulse(2);
      expect_res(2, 4, 40);
      @(negedge result_strobe[2]);
      @(posedge core_clk);
      pulse(2);
      pulse(4);
      expect_res(2, -4, 40);
      drain();
      // Overfill one channel between two loads
      pulse(4);
      pulse(1);
      expect_res(1, 4, 40);
      @(negedge result_strobe[1]);
      @(posedge core_clk);
      pulse(4);
      for (int k = 0; k < 20; k++)
      begin
         pulse(1);
         if (k < 15)
            expect_res(1, 4 + 4 * k, 40);
      end
      rd(`TDCR_ADDR_STAT, 32'h0000_00D2, 32'h0000_03FF);
      drain();
      rd(`TDCR_ADDR_STAT, 32'h0000_00F0, 32'h0000_03FF);
      // Falling sync and event edges pick the matching correction
      cal_a[3] = -16;
      bus(1'b1, 8'h7C, 32'hFFFF_FFF0);
      bus(1'b1, `TDCR_ADDR_CTRL, 32'h0018_1304);
      pulse(4);
      pulse(3);
      expect_res(3, 4, 40);
      drain();
      rd(8'h1C, 32'(4 + cal_a[3]), 32'hFFFF_FFFF);
      // Overtemperature set, hold, clear, then monitoring off
      overtemp_sense <= 1'b1;
      repeat (10) @(posedge core_clk);
      `CHK({power_down, ot_oe}, 2'b11)
      overtemp_sense <= 1'b0;
      repeat (6) @(posedge core_clk);
      rd(`TDCR_ADDR_STAT, 32'h0000_0300, 32'h0000_0300);
      bus(1'b1, `TDCR_ADDR_CMD, 32'h1);
      repeat (3) @(posedge core_clk);
      rd(`TDCR_ADDR_STAT, 32'h0, 32'h0000_0300);
      bus(1'b1, `TDCR_ADDR_CTRL, 32'h0000_0304);
      overtemp_sense <= 1'b1;
      repeat (10) @(posedge core_clk);
      rd(`TDCR_ADDR_STAT, 32'h0, 32'h0000_0300);
      `CHK({power_down, ot_oe}, 2'b00)
      overtemp_sense <= 1'b0;
      // Mid-run reset brings monitoring and the defaults back
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd(`TDCR_ADDR_CTRL, `TDCR_CTRL_RESET, 32'hFFFF_FFFF);
      rd(`TDCR_ADDR_STAT, 32'h0000_00F0, 32'h0000_03FF);
      // Result clock period per select code, last pass in double-rate mode
      for (int s = 0; s < 4; s++)
      begin
         bus(1'b1, `TDCR_ADDR_CTRL, 32'h0000_1304 | 32'((s % 3) << 4) | ((s == 3) ? 32'h0000_0040 : 32'h0000_0000));
         repeat (400) @(posedge core_clk);
         @(posedge result_clk);
         t0 = $time;
         @(posedge result_clk);
         `CHK(int'(($time - t0) / 25), (s == 3) ? 16 : 8 >> s)
      end
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
